// ==== hpp_pkg.sv ====
// Shared constants and carriers for the host parallel port.
// Assumes a single core clock domain and an internal word-wide memory bus.
package hpp_pkg;
  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int unsigned addr_w = 16;
  localparam int unsigned data_w = 16;
  localparam int unsigned fifo_depth = 4;
  localparam logic [1:0] sel_ctrl = 2'h0;
  localparam logic [1:0] sel_data_inc = 2'h1;
  localparam logic [1:0] sel_addr = 2'h2;
  localparam logic [1:0] sel_data = 2'h3;
  localparam int unsigned ctl_proc_irq = 2;
  localparam int unsigned ctl_host_irq = 3;
  localparam int unsigned ctl_byte_order = 0;
  localparam logic [15:0] ctl_reset = 16'h0000;
  localparam logic [15:0] addr_reset = 16'h0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_mem = 2'b01,
    st_done = 2'b10
  } port_state_t;
endpackage : hpp_pkg

// ==== host_parallel_port.sv ====
// Host parallel port: byte-wide multiplexed or 16-bit separate-bus slave
// into on-chip memory. Holds each memory request until mem_ack, however many
// core cycles the answer takes, and assumes host pins are asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Request FIFO
// ----------------------------------------
module req_fifo #(
  parameter int unsigned width = 33,
  parameter int unsigned depth = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int unsigned aw = $clog2(depth);
  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [aw:0] wp;
    logic [aw:0] rp;
  } fifo_st_t;
  fifo_st_t st_ff, nxt_st;
  logic full, empty;

  assign empty = st_ff.wp == st_ff.rp;
  assign full = (st_ff.wp[aw-1:0] == st_ff.rp[aw-1:0]) && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_ff.mem[st_ff.rp[aw-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wp[aw-1:0]] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : req_fifo

// Summary of operation
// - Slave only; serves host reads and writes to on-chip memory and port registers.
// - Host pins resynchronised to core clock; memory open to both anytime.
// - On contention host wins; processor stalled one port cycle.
// - Byte mode moves each word as two bytes, half select marks byte.
// - Byte mode: address, data host-only; control reachable by both sides.
// - Port disabled or wide mode: eight data pins become general I/O.
// - Wide mode uses 16-bit address bus and 16-bit data bus.
// - Wide mode stalls via ready low; host waits for ready.
// - Wide mode gives the host no control register access.
// - Wide mode: every host access launches a memory bus access.
// - Wide mode offers no interrupts in either direction.
// - Wide mode select latched on the two edges after reset release, kept until next reset.
// - Autoincrementing sequential and random-address transfers both supported.
// - Byte mode lets host and processor interrupt each other.
// - Transfers continue during emulation stop.
// - Whole on-chip RAM range reachable through the memory bus.
// - Byte mode: keeper enable switches data pin keepers.
// - Wide mode: data keepers always on, enable switches address keepers.
// - Keeper enable cleared by reset.
// - In idle, request only access clocks, never wake the core.
module host_parallel_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Straps and configuration
  input wire logic wide_mode_select,
  input wire logic port_enable_bit,
  input wire logic host_keeper_enable_wr,
  input wire logic host_keeper_enable_val,
  input wire logic core_idle,
  input wire logic emu_stop,
  // Host strobes
  input wire logic port_chip_select_n,
  input wire logic data_strobe_one_n,
  input wire logic data_strobe_two_n,
  input wire logic host_read_write,
  input wire logic byte_half_select,
  input wire logic [1:0] register_select_inputs,
  input wire logic [15:0] host_addr_bus,
  // Host data pins, low bytes double as general I/O
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic [15:0] host_data_oe_n,
  output logic host_ready_out,
  output logic host_irq_n,
  // General I/O on the eight data pins
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_dir,
  output logic [7:0] gpio_in,
  // Processor side control register
  input wire logic ctl_wr,
  input wire logic [15:0] ctl_wdata,
  output logic [15:0] ctl_rdata,
  output logic proc_irq,
  // Keepers and clocking
  output logic data_keeper_on,
  output logic addr_keeper_on,
  output logic access_clk_req,
  // Internal memory bus
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic proc_hold
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] rst_sync;
    logic wide;
    logic [2:0] stb_s1;
    logic [2:0] stb_s2;
    logic stb_prev;
    logic [15:0] ctl;
    logic [15:0] addr;
    logic [15:0] data;
    logic hi_done;
    logic keeper;
    hpp_pkg::port_state_t state;
    logic rd_pending;
    logic inc_after;
    logic ready;
    logic [15:0] dout;
    logic [15:0] oe_n;
    logic [7:0] gpi_s1;
    logic [7:0] gpi_s2;
    logic hold;
    logic clk_req;
    logic mreq;
  } port_st_t;
  port_st_t st_ff, nxt_st;

  logic stb_active, stb_rise, stb_fall, fifo_in_ready, fifo_out_valid;
  logic fifo_pop;
  hpp_pkg::mem_req_t push_req, head_req;

  function automatic logic [15:0] put_byte(input logic [15:0] w,
      input logic hi, input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : put_byte

  function automatic logic [7:0] get_byte(input logic [15:0] w,
      input logic hi);
    get_byte = hi ? w[15:8] : w[7:0];
  endfunction : get_byte

  // Strobe taken only from the second synchroniser stage
  assign stb_active = !st_ff.stb_s2[0] && !(st_ff.stb_s2[1] && st_ff.stb_s2[2]);
  assign stb_rise = stb_active && !st_ff.stb_prev;
  assign stb_fall = !stb_active && st_ff.stb_prev;
  // Pop only once answered, so the head stays on the bus while it waits
  assign fifo_pop = (st_ff.state == hpp_pkg::st_mem) && mem_ack;

  req_fifo #(.width($bits(hpp_pkg::mem_req_t)),
             .depth(hpp_pkg::fifo_depth)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(nxt_st.mreq && !st_ff.mreq),
    .in_ready(fifo_in_ready),
    .in_data(push_req),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(head_req)
  );

  always_comb begin
    nxt_st = st_ff;
    push_req = '0;
    // Strap sampled until reset release plus two edges
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    if (!st_ff.rst_sync[1]) begin
      nxt_st.wide = wide_mode_select;
    end
    nxt_st.stb_s1 = {data_strobe_two_n, data_strobe_one_n,
                     port_chip_select_n};
    nxt_st.stb_s2 = st_ff.stb_s1;
    nxt_st.stb_prev = stb_active;
    nxt_st.gpi_s1 = host_data_in[7:0];
    nxt_st.gpi_s2 = st_ff.gpi_s1;
    nxt_st.mreq = 1'b0;
    nxt_st.hold = 1'b0;
    if (host_keeper_enable_wr) begin
      nxt_st.keeper = host_keeper_enable_val;
    end
    if (ctl_wr) begin
      nxt_st.ctl = ctl_wdata;
    end
    // Host strobe handling; wide pins use host_data_in as data
    if (stb_rise && st_ff.rst_sync[1]) begin
      nxt_st.ready = 1'b0;
      if (st_ff.wide) begin
        nxt_st.addr = host_addr_bus;
        nxt_st.mreq = 1'b1;
        push_req.we = !host_read_write;
        push_req.addr = host_addr_bus;
        push_req.wdata = host_data_in;
        nxt_st.rd_pending = host_read_write;
      end else if (port_enable_bit) begin
        case (register_select_inputs)
          hpp_pkg::sel_ctrl: begin
            if (!host_read_write) begin
              // Host sets processor irq, clears its own by writing one
              if (host_data_in[hpp_pkg::ctl_proc_irq]) begin
                nxt_st.ctl[hpp_pkg::ctl_proc_irq] = 1'b1;
              end
              if (host_data_in[hpp_pkg::ctl_host_irq] && !ctl_wr) begin
                nxt_st.ctl[hpp_pkg::ctl_host_irq] = 1'b0;
              end
            end
            nxt_st.ready = 1'b1;
          end
          hpp_pkg::sel_addr: begin
            if (!host_read_write) begin
              nxt_st.addr = put_byte(st_ff.addr, !byte_half_select,
                                     host_data_in[7:0]);
            end
            nxt_st.ready = 1'b1;
          end
          hpp_pkg::sel_data, hpp_pkg::sel_data_inc: begin
            nxt_st.inc_after = register_select_inputs == hpp_pkg::sel_data_inc;
            if (!host_read_write) begin
              nxt_st.data = put_byte(st_ff.data, !byte_half_select,
                                     host_data_in[7:0]);
              // Word completes on second byte
              if (byte_half_select) begin
                nxt_st.mreq = 1'b1;
                push_req.we = 1'b1;
                push_req.addr = st_ff.addr;
                push_req.wdata = nxt_st.data;
              end else begin
                nxt_st.ready = 1'b1;
              end
            end else if (!byte_half_select) begin
              nxt_st.mreq = 1'b1;
              push_req.addr = st_ff.addr;
              nxt_st.rd_pending = 1'b1;
            end else begin
              nxt_st.ready = 1'b1;
              if (st_ff.inc_after) begin
                nxt_st.addr = st_ff.addr + 16'h0001;
              end
            end
          end
          default: nxt_st.ready = 1'b1;
        endcase
      end
    end
    if (nxt_st.mreq && !fifo_in_ready) begin
      // Full queue: request dropped, not queued; host kept stalled
      nxt_st.mreq = 1'b0;
      nxt_st.ready = 1'b0;
    end
    // Memory sequencer; runs regardless of emulation stop
    case (st_ff.state)
      hpp_pkg::st_idle: begin
        if (fifo_out_valid) begin
          nxt_st.state = hpp_pkg::st_mem;
          nxt_st.hold = 1'b1;
        end
      end
      hpp_pkg::st_mem: begin
        nxt_st.hold = 1'b1;
        if (mem_ack) begin
          nxt_st.state = hpp_pkg::st_done;
          if (st_ff.rd_pending) begin
            nxt_st.data = mem_rdata;
            nxt_st.rd_pending = 1'b0;
          end else if (!st_ff.wide && st_ff.inc_after) begin
            nxt_st.addr = st_ff.addr + 16'h0001;
          end
        end
      end
      hpp_pkg::st_done: begin
        nxt_st.state = hpp_pkg::st_idle;
        nxt_st.ready = 1'b1;
      end
      default: nxt_st.state = hpp_pkg::st_idle;
    endcase
    nxt_st.clk_req = core_idle && (fifo_out_valid ||
                     st_ff.state != hpp_pkg::st_idle);
    // Pin drive; byte pins to gpio when disabled or wide
    nxt_st.oe_n = 16'hffff;
    nxt_st.dout = 16'h0000;
    if (st_ff.wide || !port_enable_bit) begin
      nxt_st.oe_n[7:0] = ~gpio_dir;
      nxt_st.dout[7:0] = gpio_out;
    end
    if (stb_active && host_read_write && nxt_st.ready) begin
      if (st_ff.wide) begin
        nxt_st.oe_n = 16'h0000;
        nxt_st.dout = st_ff.data;
      end else if (port_enable_bit) begin
        nxt_st.oe_n[7:0] = 8'h00;
        case (register_select_inputs)
          hpp_pkg::sel_ctrl: nxt_st.dout[7:0] = st_ff.ctl[7:0];
          hpp_pkg::sel_addr: nxt_st.dout[7:0] =
            get_byte(st_ff.addr, !byte_half_select);
          default: nxt_st.dout[7:0] = get_byte(st_ff.data, !byte_half_select);
        endcase
      end
    end
    if (stb_fall) begin
      nxt_st.ready = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      st_ff.stb_s1 <= 3'h7;
      st_ff.stb_s2 <= 3'h7;
      st_ff.ctl <= hpp_pkg::ctl_reset;
      st_ff.addr <= hpp_pkg::addr_reset;
      st_ff.keeper <= 1'b0;
      st_ff.ready <= 1'b1;
      st_ff.oe_n <= 16'hffff;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign host_data_out = st_ff.dout;
  assign host_data_oe_n = st_ff.oe_n;
  assign host_ready_out = st_ff.ready;
  assign host_irq_n = st_ff.wide || !st_ff.ctl[hpp_pkg::ctl_host_irq];
  assign proc_irq = !st_ff.wide && st_ff.ctl[hpp_pkg::ctl_proc_irq];
  assign ctl_rdata = st_ff.ctl;
  assign gpio_in = st_ff.gpi_s2;
  assign data_keeper_on = st_ff.wide || st_ff.keeper;
  assign addr_keeper_on = st_ff.wide && st_ff.keeper;
  assign access_clk_req = st_ff.clk_req;
  assign mem_req = st_ff.state == hpp_pkg::st_mem;
  assign mem_we = head_req.we;
  assign mem_addr = head_req.addr;
  assign mem_wdata = head_req.wdata;
  assign proc_hold = st_ff.hold;
endmodule : host_parallel_port

`default_nettype wire

// ==== hpp_props.sv ====
// Checker for the host parallel port, watching top-level ports only.
// Assumes the strap is held steady while reset is released.
`timescale 1ns/1ns
`default_nettype none
module hpp_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Host side
  input wire logic wide_mode_select,
  input wire logic port_enable_bit,
  input wire logic port_chip_select_n,
  input wire logic data_strobe_one_n,
  input wire logic data_strobe_two_n,
  input wire logic host_keeper_enable_wr,
  input wire logic host_keeper_enable_val,
  input wire logic [15:0] host_data_in,
  input wire logic host_ready_out,
  input wire logic host_irq_n,
  input wire logic proc_irq,
  input wire logic [7:0] gpio_in,
  input wire logic data_keeper_on,
  input wire logic addr_keeper_on,
  // Memory side
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack
);
  // ---
  // Helpers and properties
  // ---
  logic [1:0] up_ff;
  logic up;
  logic acc;
  assign up = (up_ff == 2'h3);
  assign acc = !port_chip_select_n && !(data_strobe_one_n && data_strobe_two_n);
  // Mode and keeper outputs need a few edges after release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) up_ff <= 2'h0;
    else if (!up) up_ff <= up_ff + 2'h1;
  end
  default clocking dck @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_keeper_rst: assert property (
    up_ff == 2'h0 |-> !addr_keeper_on && (wide_mode_select || !data_keeper_on))
    else $error("keeper enable not clear after reset");
  chk_wide_keeps: assert property (
    up && wide_mode_select |-> data_keeper_on)
    else $error("data keepers off in wide mode");
  chk_byte_addr_keep: assert property (
    up && !wide_mode_select |-> !addr_keeper_on)
    else $error("address keepers on in byte mode");
  chk_keeper_load: assert property (
    up && host_keeper_enable_wr |=> (wide_mode_select ? addr_keeper_on
      : data_keeper_on) == $past(host_keeper_enable_val))
    else $error("keeper enable not loaded");
  chk_wide_no_irq: assert property (
    up && wide_mode_select |-> host_irq_n && !proc_irq)
    else $error("interrupt raised in wide mode");
  chk_mem_launch: assert property (
    up && $rose(acc) && wide_mode_select |-> ##[1:12] mem_req)
    else $error("wide access launched no memory access");
  chk_ready_stall: assert property (
    up && $rose(acc) && wide_mode_select |-> ##[1:12] !host_ready_out)
    else $error("wide access never stalled");
  chk_ack_ready: assert property (
    mem_req && mem_ack |-> ##[1:6] host_ready_out)
    else $error("ready not returned after memory answer");
  chk_req_steady: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped or moved before answer");
  chk_gpio_sync: assert property (
    up && (!port_enable_bit || wide_mode_select)
      |-> gpio_in == $past(host_data_in[7:0], 2))
    else $error("general inputs do not follow data pins");
  cp_mem: cover property (mem_req && mem_ack);
  cp_pirq: cover property (proc_irq);
  cp_hirq: cover property (!host_irq_n);
endmodule : hpp_props
bind host_parallel_port hpp_props u_hpp_props (.core_clk, .arst_n,
  .wide_mode_select, .port_enable_bit, .port_chip_select_n,
  .data_strobe_one_n, .data_strobe_two_n, .host_keeper_enable_wr,
  .host_keeper_enable_val, .host_data_in, .host_ready_out, .host_irq_n,
  .proc_irq, .gpio_in, .data_keeper_on, .addr_keeper_on, .mem_req,
  .mem_addr, .mem_ack);
`default_nettype wire

// ==== hpp_host_model.sv ====
// Behavioural host processor driving the port's strobe side.
// Assumes the bench calls acc only after reset has been released.
`timescale 1ns/1ns
`default_nettype none
module hpp_host_model (
  // Clock
  input wire logic core_clk,
  // Strobes and buses
  output logic port_chip_select_n,
  output logic data_strobe_one_n,
  output logic data_strobe_two_n,
  output logic host_read_write,
  output logic byte_half_select,
  output logic [1:0] register_select_inputs,
  output logic [15:0] host_addr_bus,
  output logic [15:0] host_data_in,
  // Answer
  input wire logic host_ready_out,
  input wire logic [15:0] host_data_out
);
  // ---
  // One access, held until ready is seen high
  // ---
  logic tg = 1'b0;
  initial begin
    {port_chip_select_n, data_strobe_one_n, data_strobe_two_n} = 3'h7;
    {host_read_write, byte_half_select, register_select_inputs} = 4'h8;
    host_addr_bus = 16'h0;
    host_data_in = 16'h0;
  end
  task automatic acc(input logic w, input logic [1:0] s, input logic h,
    input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    tg = ~tg;
    // Alternate strobes so both inputs see use
    port_chip_select_n <= 1'b0;
    data_strobe_one_n <= tg;
    data_strobe_two_n <= ~tg;
    host_read_write <= ~w;
    register_select_inputs <= s;
    byte_half_select <= h;
    host_addr_bus <= a;
    host_data_in <= w ? d : ~host_data_in;
    do begin
      @(posedge core_clk);
      n++;
    end while (host_ready_out && n < 16);
    while (!host_ready_out && n < 64) begin
      @(posedge core_clk);
      n++;
    end
    q = (n < 64) ? host_data_out : 16'hxxxx;
    {port_chip_select_n, data_strobe_one_n, data_strobe_two_n} <= 3'h7;
    // Released lines must not keep showing the old value
    host_addr_bus <= ~a;
    host_data_in <= ~host_data_in;
    repeat (3) @(posedge core_clk);
  endtask : acc
endmodule : hpp_host_model
`default_nettype wire

// ==== host_parallel_port_tb.sv ====
// Self-checking bench for the host parallel port.
// Assumes the host model partner and the memory answer logic below.
`timescale 1ns/1ns
`default_nettype none
module host_parallel_port_tb;
  // ---
  // Signals, memory answer and checks
  // ---
  logic core_clk = 1'b0, arst_n = 1'b0, wide_mode_select = 1'b0;
  logic port_enable_bit = 1'b0, core_idle = 1'b0, emu_stop = 1'b0;
  logic host_keeper_enable_wr = 1'b0, host_keeper_enable_val = 1'b0;
  logic ctl_wr = 1'b0, mem_ack = 1'b0;
  logic [7:0] gpio_out = 8'h0, gpio_dir = 8'h0;
  logic [15:0] ctl_wdata = 16'h0, mem_rdata = 16'h0;
  logic [15:0] lw_a = 16'h0, lw_d = 16'h0;
  logic [31:0] seed = 32'h65d4;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  logic port_chip_select_n, data_strobe_one_n, data_strobe_two_n;
  logic host_read_write, byte_half_select, host_ready_out, host_irq_n;
  logic proc_irq, data_keeper_on, addr_keeper_on, mem_req, mem_we;
  logic access_clk_req, proc_hold;
  logic [1:0] register_select_inputs;
  logic [7:0] gpio_in;
  logic [15:0] host_addr_bus, host_data_in, host_data_out, host_data_oe_n;
  logic [15:0] ctl_rdata, mem_addr, mem_wdata;
  host_parallel_port u_host_parallel_port (.core_clk, .arst_n,
    .wide_mode_select, .port_enable_bit, .host_keeper_enable_wr,
    .host_keeper_enable_val, .core_idle, .emu_stop, .port_chip_select_n,
    .data_strobe_one_n, .data_strobe_two_n, .host_read_write,
    .byte_half_select, .register_select_inputs, .host_addr_bus,
    .host_data_in, .host_data_out, .host_data_oe_n, .host_ready_out,
    .host_irq_n, .gpio_out, .gpio_dir, .gpio_in, .ctl_wr, .ctl_wdata,
    .ctl_rdata, .proc_irq, .data_keeper_on, .addr_keeper_on,
    .access_clk_req, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .proc_hold);
  hpp_host_model u_hpp_host_model (.core_clk, .port_chip_select_n,
    .data_strobe_one_n, .data_strobe_two_n, .host_read_write,
    .byte_half_select, .register_select_inputs, .host_addr_bus,
    .host_data_in, .host_ready_out, .host_data_out);
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [15:0] mword(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5a3c;
  endfunction : mword
  // Memory answers after a random stall; idle data keeps changing
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    gpio_out <= 8'(xs());
    if (mem_req) begin
      cb(proc_hold, 1'b1);
      cb(access_clk_req, core_idle);
    end
    if (mem_req && !mem_ack && xs() % 3 != 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= mword(mem_addr);
      if (mem_we) {lw_a, lw_d} <= {mem_addr, mem_wdata};
    end
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic cw(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : cw
  task automatic cb(input logic g, input logic e);
    cw({15'h0, g}, {15'h0, e});
  endtask : cb
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // ---
  // Bus tasks and sequence
  // ---
  task automatic rst(input logic w);
    @(posedge core_clk);
    arst_n <= 1'b0;
    wide_mode_select <= w;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rst
  task automatic keep(input logic v);
    host_keeper_enable_wr <= 1'b1;
    host_keeper_enable_val <= v;
    @(posedge core_clk);
    host_keeper_enable_wr <= 1'b0;
    @(posedge core_clk);
  endtask : keep
  task automatic bw(input logic w, input logic [1:0] s, input logic [15:0] d,
    output logic [15:0] q);
    logic [15:0] q0, q1;
    u_hpp_host_model.acc(w, s, 1'b0, 16'h0, {~d[15:8], d[15:8]}, q0);
    u_hpp_host_model.acc(w, s, 1'b1, 16'h0, {~d[7:0], d[7:0]}, q1);
    q = {q0[7:0], q1[7:0]};
  endtask : bw
  initial begin
    logic [15:0] q, a, d;
    rst(1'b0);
    cb(host_ready_out, 1'b1);
    cw(host_data_oe_n, 16'hffff);
    cb(data_keeper_on, 1'b0);
    port_enable_bit <= 1'b1;
    a = 16'(xs());
    bw(1'b1, hpp_pkg::sel_addr, a, q);
    for (int i = 0; i < 3; i++) begin
      d = 16'(xs());
      bw(1'b1, hpp_pkg::sel_data_inc, d, q);
      cw(lw_a, a + 16'(i));
      cw(lw_d, d);
    end
    bw(1'b1, hpp_pkg::sel_addr, 16'h7fff, q);
    for (int i = 0; i < 2; i++) begin
      bw(1'b0, hpp_pkg::sel_data_inc, 16'h0, q);
      cw(q, mword(16'h7fff + 16'(i)));
    end
    bw(1'b1, hpp_pkg::sel_ctrl, 16'h1 << hpp_pkg::ctl_proc_irq, q);
    repeat (4) @(posedge core_clk);
    cb(proc_irq, 1'b1);
    ctl_wr <= 1'b1;
    ctl_wdata <= 16'h1 << hpp_pkg::ctl_host_irq;
    @(posedge core_clk);
    ctl_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
    cb(host_irq_n, 1'b0);
    bw(1'b0, hpp_pkg::sel_ctrl, 16'h0, q);
    cb(q[hpp_pkg::ctl_host_irq], 1'b1);
    keep(1'b1);
    cb(data_keeper_on, 1'b1);
    port_enable_bit <= 1'b0;
    d = ~lw_d;
    bw(1'b1, hpp_pkg::sel_data, d, q);
    cb(lw_d === d, 1'b0);
    $display("test byte mode done");
    rst(1'b1);
    cb(addr_keeper_on, 1'b0);
    keep(1'b1);
    cb(addr_keeper_on, 1'b1);
    core_idle <= 1'b1;
    emu_stop <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 16'hffff : 16'(xs());
      d = 16'(xs());
      u_hpp_host_model.acc(1'b1, 2'h0, 1'b0, a, d, q);
      cw(lw_a, a);
      cw(lw_d, d);
      u_hpp_host_model.acc(1'b0, 2'h0, 1'b0, a, 16'h0, q);
      cw(q, mword(a));
      ctl_wr <= i[0];
    end
    ctl_wr <= 1'b0;
    $display("test wide mode done");
    finish_test();
  end
endmodule : host_parallel_port_tb
`default_nettype wire
